// file: rtl/fts_defines.svh
`ifndef FTS_DEFINES_SVH
`define FTS_DEFINES_SVH

// Register byte offsets
`define FTS_OFS_CTRL 8'h00
`define FTS_OFS_STATUS 8'h04
`define FTS_OFS_CHARS 8'h08
`define FTS_OFS_TBL_ADDR 8'h0c
`define FTS_OFS_PTR_DATA 8'h10
`define FTS_OFS_MEM_DATA 8'h14

// Control register field positions
`define FTS_CTRL_IDX_LSB 0
`define FTS_CTRL_IDX_MSB 5
`define FTS_CTRL_OUT_EN_BIT 8
`define FTS_CTRL_BYPASS_BIT 9
`define FTS_CTRL_START_BIT 16

// Status register field positions
`define FTS_STAT_BUSY_BIT 0
`define FTS_STAT_DONE_BIT 1
`define FTS_STAT_CNT_LSB 8
`define FTS_STAT_CNT_MSB 17

// Character register field positions
`define FTS_CHR_TR_LSB 0
`define FTS_CHR_TR_MSB 7
`define FTS_CHR_FN_LSB 8
`define FTS_CHR_FN_MSB 15
`define FTS_CHR_PIN_LSB 16
`define FTS_CHR_PIN_MSB 23

// Pointer entry layout: start address above, length below
`define FTS_PTR_LEN_LSB 0
`define FTS_PTR_LEN_MSB 9
`define FTS_PTR_START_LSB 10
`define FTS_PTR_START_MSB 19

// Character pair layout: function char above, transformed char below
`define FTS_PAIR_TR_LSB 0
`define FTS_PAIR_TR_MSB 7
`define FTS_PAIR_FN_LSB 8
`define FTS_PAIR_FN_MSB 15

// Reset values
`define FTS_RST_CHAR 8'h20
`define FTS_RST_OE 8'hff
`define FTS_RST_OUT_EN 1'b0
`define FTS_RST_BYPASS 1'b0

// Character codes
`define FTS_CHAR_SPACE 8'h20
`define FTS_CHAR_END 8'h00

// Pacing: divider period in clock cycles; with the divider active a character takes two cycles more
`define FTS_DIV_CYCLES 50000000

`endif

// file: rtl/fts_pkg.sv
package fts_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        FTS_IDLE,
        FTS_PTR,
        FTS_PTR_WAIT,
        FTS_RUN,
        FTS_MEM_WAIT,
        FTS_DONE
    } fts_state_t;

    // Main module state
    typedef struct packed {
        fts_state_t st;
        logic [5:0] idx;
        logic [5:0] run_idx;
        logic out_en;
        logic bypass;
        logic [9:0] tbl_addr;
        logic [9:0] row_start;
        logic [9:0] row_len;
        logic [9:0] cnt;
        logic done;
        logic [7:0] fn_char;
        logic [7:0] tr_char;
        logic [7:0] oe;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_s3;
        logic [7:0] pin_seen;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fts_top_t;

    // Pace module state
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } fts_pace_t;

    // Table module read state
    typedef struct packed {
        logic [19:0] ptr_rdata;
        logic [15:0] mem_rdata;
    } fts_rom_t;

endpackage

// file: rtl/fts_rom_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fts_rom_if;
    logic wr_ptr_en;
    logic wr_mem_en;
    logic [9:0] wr_addr;
    logic [19:0] wr_data;
    logic [5:0] ptr_raddr;
    logic [19:0] ptr_rdata;
    logic [9:0] mem_raddr;
    logic [15:0] mem_rdata;

    modport ctrl (
        output wr_ptr_en, wr_mem_en, wr_addr, wr_data, ptr_raddr, mem_raddr,
        input ptr_rdata, mem_rdata
    );
    modport rom (
        input wr_ptr_en, wr_mem_en, wr_addr, wr_data, ptr_raddr, mem_raddr,
        output ptr_rdata, mem_rdata
    );
endinterface

`default_nettype wire

// file: rtl/fts_rom.sv
`timescale 1ns/1ps
`default_nettype none

module fts_rom
    import fts_pkg::*;
(
    input wire logic i_clk,
    fts_rom_if.rom bus
);
    logic [19:0] ptr_mem [0:63];
    logic [15:0] pair_mem [0:1023];
    fts_rom_t state;
    fts_rom_t next_state;

    // Table writes from the register side
    always_ff @(posedge i_clk) begin
        if (bus.wr_ptr_en) begin
            ptr_mem[bus.wr_addr[5:0]] <= bus.wr_data;
        end
        if (bus.wr_mem_en) begin
            pair_mem[bus.wr_addr] <= bus.wr_data[15:0];
        end
    end

    // One-cycle read of both tables
    always_comb begin
        next_state = state;
        next_state.ptr_rdata = ptr_mem[bus.ptr_raddr];
        next_state.mem_rdata = pair_mem[bus.mem_raddr];
    end

    always_ff @(posedge i_clk) begin
        state <= next_state;
    end

    assign bus.ptr_rdata = state.ptr_rdata;
    assign bus.mem_rdata = state.mem_rdata;
endmodule

`default_nettype wire

// file: rtl/fts_pace.sv
`timescale 1ns/1ps
`default_nettype none

`include "fts_defines.svh"

module fts_pace
    import fts_pkg::*;
#(
    parameter int DIV_CYCLES = `FTS_DIV_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_run,
    input wire logic i_bypass,
    output logic o_tick
);
    fts_pace_t state;
    fts_pace_t next_state;

    // Tick every cycle in bypass, else once per divider period
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (!i_run) begin
            next_state.cnt = 32'h0000_0000;
        end else if (i_bypass) begin
            next_state.tick = 1'b1;
            next_state.cnt = 32'h0000_0000;
        end else if (state.cnt >= 32'(DIV_CYCLES - 1)) begin
            next_state.tick = 1'b1;
            next_state.cnt = 32'h0000_0000;
        end else begin
            next_state.cnt = state.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_tick = state.tick;
endmodule

`default_nettype wire

// file: rtl/fts_top.sv
// Summary of operation
// RQ1: The host picks a stored row by writing an index from 0 to 43 into the select field.
// RQ2: The host resets the block and then issues a start request to print a row.
// RQ3: The host sets the index before start; the index is latched at start and later changes wait.
// RQ4: After start the row is emitted one pair per step, transformed char on the two-way bus.
// RQ5: A side whose stored char marks its end shows a space until the longer side finishes.
// RQ6: Char pairs are 16-bit words, function char high, packed in a 10-bit addressed memory.
// RQ7: A 20-bit pointer entry holds start address and length, indexed by a 6-bit row number.
// RQ8: Characters begin or continue only while the output enable bit is high.
// RQ9: With bypass high one char per step at full rate, else one per divider period.
// RQ10: After the row's length in pairs the block stops and holds its outputs until restarted.
// RQ11: The two-way transformed bus is driven as output at all times.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

`include "fts_defines.svh"

module fts_top
    import fts_pkg::*;
#(
    parameter int DIV_CYCLES = `FTS_DIV_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [7:0] i_transform_char_bus,
    output logic [7:0] o_transform_char_bus,
    output logic [7:0] o_transform_char_oe,
    output logic [7:0] o_function_char_bus
);
    fts_top_t state;
    fts_top_t next_state;
    fts_rom_if rom_bus ();
    logic tick;
    logic pace_run;
    logic acc_wr;
    logic acc_rd;
    logic start_req;
    logic addr_ok;
    logic [7:0] fn_raw;
    logic [7:0] tr_raw;

    // Pair and pointer tables
    fts_rom u_rom (
        .i_clk(i_clk),
        .bus(rom_bus.rom)
    );

    // Character pacing
    fts_pace #(
        .DIV_CYCLES(DIV_CYCLES)
    ) u_pace (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_run(pace_run),
        .i_bypass(state.bypass),
        .o_tick(tick)
    );

    // Pacing runs only in the run state with output enabled
    assign pace_run = (state.st == FTS_RUN) && state.out_en; // RQ8

    // APB access completes at the edge where pready is high
    assign acc_wr = i_psel && i_penable && state.pready && i_pwrite;
    assign acc_rd = i_psel && i_penable && state.pready && !i_pwrite;
    assign start_req = acc_wr && (i_paddr == `FTS_OFS_CTRL) && i_pwdata[`FTS_CTRL_START_BIT];

    // Table write and read addressing
    assign rom_bus.wr_ptr_en = acc_wr && (i_paddr == `FTS_OFS_PTR_DATA); // RQ7
    assign rom_bus.wr_mem_en = acc_wr && (i_paddr == `FTS_OFS_MEM_DATA); // RQ6
    assign rom_bus.wr_addr = state.tbl_addr;
    assign rom_bus.wr_data = i_pwdata[19:0];
    assign rom_bus.ptr_raddr = state.run_idx; // RQ7
    assign rom_bus.mem_raddr = state.row_start + state.cnt; // RQ6

    // Pair halves from the table word
    assign fn_raw = rom_bus.mem_rdata[`FTS_PAIR_FN_MSB:`FTS_PAIR_FN_LSB];
    assign tr_raw = rom_bus.mem_rdata[`FTS_PAIR_TR_MSB:`FTS_PAIR_TR_LSB];

    // Decode of mapped offsets
    always_comb begin
        case (i_paddr)
            `FTS_OFS_CTRL,
            `FTS_OFS_STATUS,
            `FTS_OFS_CHARS,
            `FTS_OFS_TBL_ADDR,
            `FTS_OFS_PTR_DATA,
            `FTS_OFS_MEM_DATA: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Next state: bus slave, pin sync and sequencer
    always_comb begin
        next_state = state;
        next_state.oe = `FTS_RST_OE; // RQ11

        // Input pin synchroniser, a change counts when stages two and three agree
        next_state.pin_s1 = i_transform_char_bus;
        next_state.pin_s2 = state.pin_s1;
        next_state.pin_s3 = state.pin_s2;
        if (state.pin_s2 == state.pin_s3) begin
            next_state.pin_seen = state.pin_s3;
        end

        // APB: one wait cycle, answer in the second access cycle
        next_state.pready = i_psel && i_penable && !state.pready;
        next_state.pslverr = 1'b0;
        next_state.prdata = 32'h0000_0000;
        if (i_psel && i_penable && !state.pready) begin
            next_state.pslverr = !addr_ok;
            if (!i_pwrite) begin
                case (i_paddr)
                    `FTS_OFS_CTRL: begin
                        next_state.prdata[`FTS_CTRL_IDX_MSB:`FTS_CTRL_IDX_LSB] = state.idx;
                        next_state.prdata[`FTS_CTRL_OUT_EN_BIT] = state.out_en;
                        next_state.prdata[`FTS_CTRL_BYPASS_BIT] = state.bypass;
                    end
                    `FTS_OFS_STATUS: begin
                        next_state.prdata[`FTS_STAT_BUSY_BIT] =
                            (state.st != FTS_IDLE) && (state.st != FTS_DONE);
                        next_state.prdata[`FTS_STAT_DONE_BIT] = state.done;
                        next_state.prdata[`FTS_STAT_CNT_MSB:`FTS_STAT_CNT_LSB] = state.cnt;
                    end
                    `FTS_OFS_CHARS: begin
                        next_state.prdata[`FTS_CHR_TR_MSB:`FTS_CHR_TR_LSB] = state.tr_char;
                        next_state.prdata[`FTS_CHR_FN_MSB:`FTS_CHR_FN_LSB] = state.fn_char;
                        next_state.prdata[`FTS_CHR_PIN_MSB:`FTS_CHR_PIN_LSB] = state.pin_seen;
                    end
                    `FTS_OFS_TBL_ADDR: begin
                        next_state.prdata[9:0] = state.tbl_addr;
                    end
                    default: begin
                        next_state.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Register writes
        if (acc_wr) begin
            case (i_paddr)
                `FTS_OFS_CTRL: begin
                    next_state.idx = i_pwdata[`FTS_CTRL_IDX_MSB:`FTS_CTRL_IDX_LSB]; // RQ1
                    next_state.out_en = i_pwdata[`FTS_CTRL_OUT_EN_BIT];
                    next_state.bypass = i_pwdata[`FTS_CTRL_BYPASS_BIT];
                end
                `FTS_OFS_TBL_ADDR: begin
                    next_state.tbl_addr = i_pwdata[9:0];
                end
                `FTS_OFS_MEM_DATA: begin
                    next_state.tbl_addr = state.tbl_addr + 10'h001; // Stream load
                end
                default: begin
                    next_state.tbl_addr = state.tbl_addr;
                end
            endcase
        end

        // Row sequencer
        case (state.st)
            FTS_IDLE, FTS_DONE: begin
                if (start_req) begin
                    // Index taken with the start request
                    next_state.run_idx = i_pwdata[`FTS_CTRL_IDX_MSB:`FTS_CTRL_IDX_LSB]; // RQ3
                    next_state.done = 1'b0;
                    next_state.st = FTS_PTR; // RQ4
                end
            end
            FTS_PTR: begin
                next_state.st = FTS_PTR_WAIT;
            end
            FTS_PTR_WAIT: begin
                next_state.row_start =
                    rom_bus.ptr_rdata[`FTS_PTR_START_MSB:`FTS_PTR_START_LSB]; // RQ7
                next_state.row_len =
                    rom_bus.ptr_rdata[`FTS_PTR_LEN_MSB:`FTS_PTR_LEN_LSB]; // RQ7
                next_state.cnt = 10'h000;
                if (rom_bus.ptr_rdata[`FTS_PTR_LEN_MSB:`FTS_PTR_LEN_LSB] == 10'h000) begin
                    next_state.done = 1'b1;
                    next_state.st = FTS_DONE;
                end else begin
                    next_state.st = FTS_RUN;
                end
            end
            FTS_RUN: begin
                if (tick && state.out_en) begin
                    next_state.st = FTS_MEM_WAIT; // RQ8 RQ9
                end
            end
            FTS_MEM_WAIT: begin
                // Present the pair, spaces for an ended side
                next_state.fn_char = (fn_raw == `FTS_CHAR_END) ? `FTS_CHAR_SPACE : fn_raw; // RQ5
                next_state.tr_char = (tr_raw == `FTS_CHAR_END) ? `FTS_CHAR_SPACE : tr_raw; // RQ5
                next_state.cnt = state.cnt + 10'h001;
                if ((state.cnt + 10'h001) == state.row_len) begin
                    next_state.done = 1'b1;
                    next_state.st = FTS_DONE; // RQ10
                end else begin
                    next_state.st = FTS_RUN;
                end
            end
            default: begin
                next_state.st = FTS_IDLE;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= '0;
            state.st <= FTS_IDLE;
            state.out_en <= `FTS_RST_OUT_EN;
            state.bypass <= `FTS_RST_BYPASS;
            state.fn_char <= `FTS_RST_CHAR;
            state.tr_char <= `FTS_RST_CHAR;
            state.oe <= `FTS_RST_OE;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register
    assign o_prdata = state.prdata;
    assign o_pready = state.pready;
    assign o_pslverr = state.pslverr;
    assign o_function_char_bus = state.fn_char; // RQ4
    assign o_transform_char_bus = state.tr_char; // RQ4
    assign o_transform_char_oe = state.oe; // RQ11
endmodule

`default_nettype wire

// file: dv/fts_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module fts_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_fn,
    input wire logic [7:0] i_tr,
    input wire logic [7:0] i_oe,
    output logic [7:0] o_wire
);
    logic [15:0] log_q[$];
    int t_q[$];
    int cyc = 0;
    logic [15:0] last = 16'h2020;

    // Released bits show the inverse of the block's value
    assign o_wire = (i_oe & i_tr) | (~i_oe & ~i_tr);

    // Logs each new pair seen on the pins, with its cycle
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if ({i_fn, o_wire} !== last) begin
            log_q.push_back({i_fn, o_wire});
            t_q.push_back(cyc);
            last <= {i_fn, o_wire};
        end
    end
endmodule

`default_nettype wire

// file: dv/fts_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none

`include "fts_defines.svh"

module fts_top_monitor #(
    parameter int DIV_CYCLES = 50000000
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [7:0] o_transform_char_bus,
    input wire logic [7:0] o_transform_char_oe,
    input wire logic [7:0] o_function_char_bus
);
    logic mapped;

    // Offsets that answer without error
    assign mapped = i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_oe_always: assert property (o_transform_char_oe == `FTS_RST_OE)
        else $error("two-way bus not driven");
    a_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready late");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready too long");
    a_ready_cause: assert property ($rose(o_pready) |-> $past(i_psel && i_penable))
        else $error("pready without access");
    a_err_unmapped: assert property (o_pready |-> (o_pslverr == !mapped))
        else $error("pslverr wrong");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("prdata not zero");
    a_chars_reset: assert property ($past(i_srst) |-> o_function_char_bus == 8'h20
        && o_transform_char_bus == 8'h20)
        else $error("chars not space after reset");
    a_no_null: assert property (o_function_char_bus != 8'h00
        && o_transform_char_bus != 8'h00)
        else $error("null char shown");
    a_char_spacing: assert property ($changed({o_function_char_bus,
        o_transform_char_bus}) |=> $stable({o_function_char_bus, o_transform_char_bus})[*2])
        else $error("chars too close");
endmodule

bind fts_top fts_top_monitor #(.DIV_CYCLES(DIV_CYCLES)) u_mon (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_paddr(i_paddr),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_transform_char_bus(o_transform_char_bus),
    .o_transform_char_oe(o_transform_char_oe),
    .o_function_char_bus(o_function_char_bus)
);

`default_nettype wire

// file: dv/fts_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

`include "fts_defines.svh"

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("Error %0t: got %h expected %h", $time, (a), (b)); end end

module fts_top_bench;
    import fts_pkg::*;
    localparam int DIV = 12;
    logic i_clk = 0, i_srst = 1, psel = 0, pen = 0, pwr = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err;
    logic [7:0] pin, tr, oe, fn;
    int fails = 0, samples_checked = 0, cycles = 0;

    fts_top #(.DIV_CYCLES(DIV)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_transform_char_bus(pin), .o_transform_char_bus(tr),
        .o_transform_char_oe(oe), .o_function_char_bus(fn));
    fts_host_model peer (.i_clk(i_clk), .i_fn(fn), .i_tr(tr), .i_oe(oe), .o_wire(pin));

    // Clock and watchdog
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Start code: start bit, bypass, enable, index
    function automatic logic [31:0] ctl(logic [5:0] idx, logic en, logic byp, logic go);
        return {15'h0, go, 6'h0, byp, en, 2'h0, idx};
    endfunction

    task automatic wait_done();
        int k;
        k = 0;
        do begin
            apb(1'b0, `FTS_OFS_STATUS, 32'h0);
            k++;
        end while (q[1] !== 1'b1 && k < 100);
    endtask

    task automatic chk_log(input logic [15:0] exp[]);
        `CHK(peer.log_q.size(), exp.size())
        foreach (exp[i]) begin
            if (i < peer.log_q.size()) `CHK(peer.log_q[i], exp[i])
        end
        peer.log_q.delete();
        peer.t_q.delete();
    endtask

    task automatic t_reset();
        `CHK(fn, 8'h20)
        `CHK(tr, 8'h20)
        `CHK(oe, 8'hff)
        apb(1'b0, `FTS_OFS_CTRL, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, `FTS_OFS_STATUS, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, 8'h18, 32'h0);
        `CHK({err, q}, {1'b1, 32'h0})
        $display("test reset done");
    endtask

    // Rows 5 (three pairs), 7 (empty), 43 (wraps past the top address)
    task automatic t_load();
        apb(1'b1, `FTS_OFS_TBL_ADDR, 32'd5);
        apb(1'b1, `FTS_OFS_PTR_DATA, {12'h0, 10'd100, 10'd3});
        apb(1'b1, `FTS_OFS_TBL_ADDR, 32'd7);
        apb(1'b1, `FTS_OFS_PTR_DATA, {12'h0, 10'd200, 10'd0});
        apb(1'b1, `FTS_OFS_TBL_ADDR, 32'd43);
        apb(1'b1, `FTS_OFS_PTR_DATA, {12'h0, 10'd1023, 10'd2});
        apb(1'b1, `FTS_OFS_TBL_ADDR, 32'd100);
        apb(1'b1, `FTS_OFS_MEM_DATA, 32'h4178);
        apb(1'b1, `FTS_OFS_MEM_DATA, 32'h4200);
        apb(1'b1, `FTS_OFS_MEM_DATA, 32'h007a);
        apb(1'b1, `FTS_OFS_TBL_ADDR, 32'd1023);
        apb(1'b1, `FTS_OFS_MEM_DATA, 32'h5070);
        apb(1'b1, `FTS_OFS_MEM_DATA, 32'h5171);
        apb(1'b0, `FTS_OFS_TBL_ADDR, 32'h0);
        `CHK(q, 32'd1)
        $display("test load done");
    endtask

    task automatic t_bypass_row();
        apb(1'b1, `FTS_OFS_CTRL, ctl(6'd5, 1'b1, 1'b1, 1'b1));
        apb(1'b1, `FTS_OFS_CTRL, ctl(6'd7, 1'b1, 1'b1, 1'b0));
        apb(1'b0, `FTS_OFS_CTRL, 32'h0);
        `CHK(q, 32'h0307)
        wait_done();
        `CHK(q, 32'h0302)
        `CHK(peer.t_q[1] - peer.t_q[0], 3)
        chk_log('{16'h4178, 16'h4220, 16'h207a});
        apb(1'b0, `FTS_OFS_CHARS, 32'h0);
        `CHK(q, 32'h007a207a)
        $display("test bypass row done");
    endtask

    task automatic t_empty_row();
        apb(1'b1, `FTS_OFS_CTRL, ctl(6'd7, 1'b1, 1'b1, 1'b1));
        wait_done();
        `CHK(q, 32'h0002)
        chk_log('{});
        $display("test empty row done");
    endtask

    task automatic t_gated_row();
        apb(1'b1, `FTS_OFS_CTRL, ctl(6'd43, 1'b0, 1'b1, 1'b1));
        repeat (40) @(posedge i_clk);
        `CHK(peer.log_q.size(), 0)
        apb(1'b0, `FTS_OFS_STATUS, 32'h0);
        `CHK(q, 32'h0001)
        apb(1'b1, `FTS_OFS_CTRL, ctl(6'd43, 1'b1, 1'b1, 1'b0));
        wait_done();
        chk_log('{16'h5070, 16'h5171});
        $display("test gated row done");
    endtask

    task automatic t_divided_row();
        logic ok;
        apb(1'b1, `FTS_OFS_CTRL, ctl(6'd5, 1'b1, 1'b0, 1'b1));
        wait_done();
        ok = (peer.t_q[1] - peer.t_q[0]) inside {[DIV : DIV + 4]};
        `CHK(ok, 1'b1)
        chk_log('{16'h4178, 16'h4220, 16'h207a});
        $display("test divided row done");
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        peer.log_q.delete();
        peer.t_q.delete();
        t_reset();
        t_load();
        t_bypass_row();
        t_empty_row();
        t_gated_row();
        t_divided_row();
        wrap_up();
    end
endmodule

`default_nettype wire
